// [adsl_defs.svh]
// Constants for the ADC diagnostic selector: offsets, fields, reset values, codes
`ifndef ADSL_DEFS_SVH
`define ADSL_DEFS_SVH
// ====================
// Register byte offsets
`define ADSL_OFS_CTRL 12'h000
`define ADSL_OFS_RESULT 12'h004
`define ADSL_OFS_STATUS 12'h008
// ====================
// Field positions and reset values
`define ADSL_SEL_LSB 0
`define ADSL_SEL_MSB 2
`define ADSL_START_BIT 4
`define ADSL_CTRL_RESET 3'h0
`define ADSL_RESULT_RESET 16'h0000
`define ADSL_CODE_LSB 2
// ====================
// Selector codes
`define ADSL_SEL_OFF 3'h0
`define ADSL_SEL_ALTERNATE_REFERENCE 3'h1
`define ADSL_SEL_SUPPLY 3'h2
`define ADSL_SEL_LEVEL_SHIFT_AMP 3'h3
`define ADSL_SEL_ZERO 3'h4
`define ADSL_SEL_FULL 3'h5
`define ADSL_SEL_TEMP 3'h6
`endif

// [adsl_pkg.sv]
// Types shared by the ADC diagnostic selector
`default_nettype none
package adsl_pkg;
  // ====================
  // Analog controls toward the measurement path
  typedef struct packed {
    logic alt_ref_in;
    logic supply_as_ref;
    logic amp_short;
    logic force_bipolar;
    logic skip_chop;
    logic drive_neg;
    logic drive_pos;
    logic temp_in;
  } adsl_ctl_t;
  // ====================
  // Sequencer states
  typedef enum logic [1:0] {
    ADSL_IDLE = 2'b00,
    ADSL_MEAS = 2'b01,
    ADSL_RESULT_REG_A = 2'b10
  } adsl_state_t;
endpackage : adsl_pkg
`default_nettype wire

// [adsl_ctl_decode.sv]
// Decoder from diagnostic selector code to analog path controls
`default_nettype none
`include "adsl_defs.svh"
module adsl_ctl_decode
  import adsl_pkg::*;
(
  input wire logic [2:0] sel,
  input wire logic result_reg_a_phase,
  output adsl_ctl_t ctl
);
  // ====================
  // Per-code control decode, active only in the diagnostic phase except skip_chop, which follows the code alone
  wire logic is_level_shift_amp = (sel == `ADSL_SEL_LEVEL_SHIFT_AMP);
  wire logic is_zero = (sel == `ADSL_SEL_ZERO);
  wire logic is_full = (sel == `ADSL_SEL_FULL);
  assign ctl.alt_ref_in = result_reg_a_phase && (sel == `ADSL_SEL_ALTERNATE_REFERENCE);
  assign ctl.supply_as_ref = result_reg_a_phase && (sel == `ADSL_SEL_SUPPLY);
  assign ctl.amp_short = result_reg_a_phase && is_level_shift_amp;
  // Bipolar forced whatever the configured polarity
  assign ctl.force_bipolar = result_reg_a_phase && (is_level_shift_amp || is_zero || is_full);
  // Chopping stays off for the whole acquisition so the offset survives
  assign ctl.skip_chop = is_level_shift_amp;
  assign ctl.drive_neg = result_reg_a_phase && is_zero;
  assign ctl.drive_pos = result_reg_a_phase && is_full;
  assign ctl.temp_in = result_reg_a_phase && (sel == `ADSL_SEL_TEMP);
endmodule : adsl_ctl_decode
`default_nettype wire

// [adsl_top.sv]
// ADC diagnostic selector with AHB-Lite register slave
//
// Summary of operation
// - Code 1 measures alternate reference
// - Code 2 converts reference using supply reference
// - Code 3 shorts level-shift amplifier inputs
// - Amplifier offset check forces bipolar polarity
// - Amplifier offset check skips chopping phase
// - Code 4 drives input to negative supply
// - Result stored when acquisition completes
// - 14-bit code sits in bits 15..2
// - Code 5 drives input to positive supply
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
`include "adsl_defs.svh"
module adsl_top
  import adsl_pkg::*;
#(
  parameter int CODE_W = 14,
  parameter int MEAS_CYCLES = 16,
  parameter logic [CODE_W-1:0] TEMP_LIMIT = 14'h3000
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic adc_done,
  input wire logic [CODE_W-1:0] adc_code,
  output adsl_ctl_t path_ctl,
  output logic result_reg_a_busy,
  output logic over_temp_alert
);
  // ====================
  // Register state
  logic [2:0] result_reg_a_select_field;
  logic [15:0] result_reg_a;
  logic result_new;
  adsl_state_t state;
  adsl_state_t next_state;
  logic [7:0] meas_cnt;
  // ====================
  // AHB-Lite address phase capture
  logic wr_pend;
  logic rd_pend;
  logic [11:0] addr_q;
  wire logic take = hsel && hready && htrans[1];
  wire logic wr_ctrl = wr_pend && (addr_q == `ADSL_OFS_CTRL);
  wire logic start_req = wr_ctrl && hwdata[`ADSL_START_BIT];
  wire logic rd_result = rd_pend && (addr_q == `ADSL_OFS_RESULT);

  // Address phase register, zero wait states
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      wr_pend <= take && hwrite;
      rd_pend <= take && !hwrite;
      addr_q <= haddr[11:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0; // Always OKAY

  // ====================
  // Read data mux; unmapped reads return zero
  wire logic [31:0] rd_ctrl = {29'h0000_0000, result_reg_a_select_field};
  wire logic [31:0] rd_res = {16'h0000, result_reg_a};
  wire logic [31:0] rd_stat = {29'h0000_0000, over_temp_alert, result_new, result_reg_a_busy};
  assign hrdata = (addr_q == `ADSL_OFS_CTRL) ? rd_ctrl :
                  (addr_q == `ADSL_OFS_RESULT) ? rd_res :
                  (addr_q == `ADSL_OFS_STATUS) ? rd_stat : 32'h0000_0000;

  // Selector write; held while an acquisition runs
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      result_reg_a_select_field <= `ADSL_CTRL_RESET;
    else if (wr_ctrl && state == ADSL_IDLE)
      result_reg_a_select_field <= hwdata[`ADSL_SEL_MSB:`ADSL_SEL_LSB];
  end

  // ====================
  // Acquisition sequencer: normal scan, then diagnostic portion
  wire logic result_reg_a_on = (result_reg_a_select_field != `ADSL_SEL_OFF);
  wire logic meas_end = (meas_cnt == 8'(MEAS_CYCLES - 1));
  always_comb
  begin
    next_state = state;
    case (state)
      ADSL_IDLE: if (start_req) next_state = ADSL_MEAS;
      ADSL_MEAS: if (meas_end) next_state = result_reg_a_on ? ADSL_RESULT_REG_A : ADSL_IDLE;
      ADSL_RESULT_REG_A: if (adc_done) next_state = ADSL_IDLE;
      default: next_state = ADSL_IDLE;
    endcase
  end

  // State and scan counter
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ADSL_IDLE;
      meas_cnt <= 8'h00;
    end
    else
    begin
      state <= next_state;
      meas_cnt <= (state == ADSL_MEAS) ? meas_cnt + 8'h01 : 8'h00;
    end
  end

  assign result_reg_a_busy = (state != ADSL_IDLE);

  // ====================
  // Path control decode
  adsl_ctl_decode adsl_ctl_decode_inst (
    .sel(result_reg_a_select_field),
    .result_reg_a_phase(state == ADSL_RESULT_REG_A),
    .ctl(path_ctl)
  );

  // ====================
  // Result capture at completion; new flag set wins over read clear
  wire logic capture = (state == ADSL_RESULT_REG_A) && adc_done;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result_reg_a <= `ADSL_RESULT_RESET;
      result_new <= 1'b0;
      over_temp_alert <= 1'b0;
    end
    else
    begin
      if (capture)
        result_reg_a <= {adc_code, 2'b00};
      if (capture)
        result_new <= 1'b1;
      else if (rd_result)
        result_new <= 1'b0;
      if (capture && result_reg_a_select_field == `ADSL_SEL_TEMP)
        over_temp_alert <= (adc_code >= TEMP_LIMIT);
    end
  end
endmodule : adsl_top
`default_nettype wire

// [adsl_checker.sv]
// Port assertions for the diagnostic selector
`default_nettype none
module adsl_checker
  import adsl_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic adc_done,
  input wire adsl_ctl_t path_ctl,
  input wire logic result_reg_a_busy,
  input wire logic over_temp_alert
);
  // ====================
  // Path control, busy and alert relations
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_level_shift_amp_bipolar: assert property (path_ctl.amp_short |-> path_ctl.force_bipolar)
    else $error("no bipolar");
  chk_level_shift_amp_nochop: assert property (path_ctl.amp_short |-> path_ctl.skip_chop)
    else $error("chop kept");
  chk_zero_bipolar: assert property (path_ctl.drive_neg |-> path_ctl.force_bipolar)
    else $error("no bipolar");
  chk_full_bipolar: assert property (path_ctl.drive_pos |-> path_ctl.force_bipolar)
    else $error("no bipolar");
  chk_idle_quiet: assert property (!result_reg_a_busy |-> (path_ctl & 8'hf7) == 8'h00)
    else $error("idle path on");
  chk_done_ends: assert property (result_reg_a_busy && adc_done && (path_ctl & 8'he7) != 8'h00
    |=> !result_reg_a_busy) else $error("busy stuck");
  chk_scan_len: assert property ($rose(result_reg_a_busy) |-> result_reg_a_busy[*8])
    else $error("short scan");
  chk_alert_cause: assert property ($changed(over_temp_alert)
    |-> $past(adc_done) && $past(path_ctl.temp_in)) else $error("stray alert");
endmodule : adsl_checker
`default_nettype wire

// [adsl_top_test.sv]
// Self-checking bench for the diagnostic selector
`default_nettype none
module adsl_top_test;
  import adsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, hsel = 1, hwrite = 0, adc_done = 0, alert, hreadyout, hresp;
  logic result_reg_a_busy, over_temp_alert;
  logic [1:0] htrans = 2'h0;
  logic [2:0] sel;
  logic [13:0] adc_code = 14'h0000, code;
  logic [15:0] res;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r, seed = 32'h141f_739c;
  adsl_ctl_t path_ctl;
  int miscompares = 0, checks = 0, n;
  // ====================
  // Clock and design
  always #2 clk = ~clk;
  adsl_top adsl_top_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .adc_done(adc_done),
    .adc_code(adc_code), .path_ctl(path_ctl), .result_reg_a_busy(result_reg_a_busy),
    .over_temp_alert(over_temp_alert));
  // ====================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] exp_ctl(input logic [2:0] s);
    case (s)
      3'h1: return 8'h80;
      3'h2: return 8'h40;
      3'h3: return 8'h38;
      3'h4: return 8'h14;
      3'h5: return 8'h12;
      default: return 8'h01;
    endcase
  endfunction : exp_ctl
  // Host view of the amplifier offset: distance of the code from mid scale
  function automatic logic [13:0] off(input logic [13:0] c);
    return (c >= 14'h2000) ? c - 14'h2000 : 14'h2000 - c;
  endfunction : off
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Waits for idle, or for the diagnostic phase when d is set
  task automatic wst(input bit d);
    n = 0;
    while (result_reg_a_busy === 1'b1 && !(d && (path_ctl & 8'he7) != 8'h00) && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) chk(0, 1);
    if (n >= 100) conclude();
  endtask : wst
  task automatic rdy;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) chk(0, 1);
    if (n >= 100) conclude();
  endtask : rdy
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask : bus
  // ====================
  // Main sequence: every selector code, corner codes and random ones
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, 12'h004, 0);
    chk(r, 0);
    bus(1, 12'h00c, 32'hffff_ffff);
    bus(0, 12'h00c, 0);
    chk(r, 0);
    res = 16'h0000;
    alert = 0;
    for (int i = 0; i < 14; i++)
    begin
      sel = 3'(i % 7);
      seed = xs(seed);
      code = (sel == 3'h4) ? 14'h0000 : (sel == 3'h5) ? 14'h3ffc : seed[13:0];
      if (sel == 3'h6) code = (i < 7) ? 14'h3fff : 14'h0001;
      if (sel == 3'h1) code = (i < 7) ? 14'h0fbe : 14'h100d;
      bus(1, 12'h000, {27'h0, 2'b10, sel});
      bus(1, 12'h000, {29'h0, ~sel});
      bus(0, 12'h000, 0);
      chk(r, {29'h0, sel});
      wst(1);
      if (sel != 3'h0)
      begin
        chk({24'h0, path_ctl}, {24'h0, exp_ctl(sel)});
        adc_done <= 1'b1;
        adc_code <= code;
        @(posedge clk);
        adc_done <= 1'b0;
        res = {code, 2'b00};
        if (sel == 3'h6) alert = (code >= 14'h3000);
      end
      wst(0);
      bus(0, 12'h008, 0);
      chk(r, {29'h0, alert, sel != 3'h0, 1'b0});
      bus(0, 12'h004, 0);
      chk(r, {16'h0, res});
      if (sel == 3'h1) chk({31'h0, r[15:0] >= 16'h3ef8 && r[15:0] <= 16'h4034}, 1);
      if (sel == 3'h3) chk({18'h0, off(r[15:2])}, {18'h0, off(code)});
    end
    // Reset again after the last acquisition: every register returns to its reset value
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, 12'h000, 0);
    chk(r, 0);
    bus(0, 12'h004, 0);
    chk(r, 0);
    bus(0, 12'h008, 0);
    chk(r, 0);
    conclude();
  end
endmodule : adsl_top_test
bind adsl_top adsl_checker adsl_checker_inst (.clk(clk), .arst_n(arst_n), .adc_done(adc_done),
  .path_ctl(path_ctl), .result_reg_a_busy(result_reg_a_busy), .over_temp_alert(over_temp_alert));
`default_nettype wire
